// *** shared/iifc_pkg.sv ***
/*
 * shared constants and carriers for the isolated input filter control block.
 * assumes an 8-bit host i/o port with a plug-and-play base address.
 */
package iifc_pkg;

	// data and window geometry
	localparam int unsigned DATA_W    = 8;
	localparam int unsigned ADDR_W    = 32;
	localparam int unsigned WIN_BITS  = 3;   // eight-address window
	localparam int unsigned NUM_INPUT = 16;

	// register offsets inside the window
	localparam logic [WIN_BITS-1:0] OFF_STATUS_A = 3'h1;
	localparam logic [WIN_BITS-1:0] OFF_FILT_A   = 3'h3;
	localparam logic [WIN_BITS-1:0] OFF_STATUS_B = 3'h5;
	localparam logic [WIN_BITS-1:0] OFF_FILT_B   = 3'h6;

	// reset and fixed read values
	localparam logic [DATA_W-1:0] FILT_RESET = 8'h00;
	localparam logic [DATA_W-1:0] READ_ZERO  = 8'h00;

	// filter time constant
	localparam int unsigned CLK_FREQ_HZ   = 125_000_000;
	localparam int unsigned FILTER_TAU_MS = 5;
	localparam int unsigned FILTER_CYCLES = (CLK_FREQ_HZ / 1000) * FILTER_TAU_MS;

	// host i/o request
	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} iifc_io_req_s;

	// device answer
	typedef struct packed {
		logic              claim;
		logic              ack;
		logic [DATA_W-1:0] rdata;
	} iifc_io_rsp_s;

endpackage

// *** design/iifc_lp_filter.sv ***
/*
 * one input's low-pass path: saturating integrator with hysteresis.
 * assumes raw_i is already synchronous to clk_i.
 */
`timescale 1ns/1ps
module iifc_lp_filter #(
	parameter int unsigned CYCLES = 625000
) (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic enable_i,
	input  wire logic raw_i,
	output logic      filtered_o
);
	import iifc_pkg::*;

	localparam int unsigned    CW   = $clog2(CYCLES + 1);
	localparam logic [CW-1:0]  FULL = CW'(CYCLES);
	localparam logic [CW-1:0]  NONE = '0;

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          out_q;
	logic          out_d;
	wire           at_full = (cnt_q == FULL);
	wire           at_none = (cnt_q == NONE);

	////////////////////////////////////////////////////////////////
	// integrator; when bypassed it rails to the raw level
	always_comb begin
		cnt_d = cnt_q;
		if (!enable_i)
			cnt_d = raw_i ? FULL : NONE;
		else if (raw_i && !at_full)
			cnt_d = cnt_q + CW'(1);
		else if (!raw_i && !at_none)
			cnt_d = cnt_q - CW'(1);
	end

	// output flips only at the rails when enabled; bypassed it follows raw_i
	always_comb begin
		out_d = out_q;
		if (!enable_i)
			out_d = raw_i;
		else if (at_full)
			out_d = 1'b1;
		else if (at_none)
			out_d = 1'b0;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= NONE;
			out_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign filtered_o = out_q;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	a_bypass_follows: assert property (!enable_i |=> out_q == $past(raw_i))
		else $error("bypassed filter did not follow raw input");
	a_filter_holds_low: assert property (enable_i && at_none && !out_q && raw_i ##1 enable_i |-> !out_q)
		else $error("filtered output rose before integration");
	c_filter_rise: cover property (enable_i && !out_q ##1 enable_i && out_q);

endmodule

// *** design/iifc_filter_ctrl.sv ***
/*
 * filter enable registers, input status readback and sixteen filtered input paths.
 * assumes 8-bit host i/o cycles, a base address aligned to eight, inputs synchronous to clk_i.
 */
//
// Contract
// - port A filter enable sits at base offset 3 and port B at offset 6.
// - writing 1 to a bit enables that input's filter and 0 disables it.
// - each enable register is 8 bits with bit n controlling input n.
// - both enable registers are all zero after reset so all filters are off.
// - the device claims all eight addresses from its base, used or not.
// - reading offset 1 or 5 returns port A or B input states, 1 meaning voltage present.
// - an enabled filter applies a low-pass of about 5 ms before the state is reported.
`timescale 1ns/1ps
module iifc_filter_ctrl #(
	parameter int unsigned FILTER_CYCLES = iifc_pkg::FILTER_CYCLES
) (
	input  wire logic                                   clk_i,
	input  wire logic                                   rst_b_i,
	input  wire logic [iifc_pkg::ADDR_W-1:0]            assigned_io_base_i,
	input  wire iifc_pkg::iifc_io_req_s                 io_req_i,
	output iifc_pkg::iifc_io_rsp_s                      io_rsp_o,
	input  wire logic [iifc_pkg::NUM_INPUT-1:0]         raw_inputs_i,
	output logic [iifc_pkg::NUM_INPUT-1:0]              filter_enable_o,
	output logic [iifc_pkg::NUM_INPUT-1:0]              filtered_inputs_o
);
	import iifc_pkg::*;

	// offset match, used for every register
	function automatic logic at_off(input logic [WIN_BITS-1:0] off, input logic [WIN_BITS-1:0] target);
		at_off = (off == target);
	endfunction

	logic [DATA_W-1:0]    en_a_q;
	logic [DATA_W-1:0]    en_b_q;
	logic [DATA_W-1:0]    rdata_q;
	logic [DATA_W-1:0]    rdata_d;
	logic                 ack_q;
	logic [NUM_INPUT-1:0] filt;

	////////////////////////////////////////////////////////////////
	// window decode against the host-assigned base
	wire [WIN_BITS-1:0] off    = io_req_i.addr[WIN_BITS-1:0];
	wire                claim  = (io_req_i.addr[ADDR_W-1:WIN_BITS]
	                              == assigned_io_base_i[ADDR_W-1:WIN_BITS]);
	wire                wr_hit = claim && io_req_i.wr;
	wire                rd_hit = claim && io_req_i.rd;
	wire                wr_a   = wr_hit && at_off(off, OFF_FILT_A);
	wire                wr_b   = wr_hit && at_off(off, OFF_FILT_B);

	// read mux; enable registers and unused offsets read zero
	assign rdata_d = at_off(off, OFF_STATUS_A) ? filt[DATA_W-1:0] :
	                 at_off(off, OFF_STATUS_B) ? filt[NUM_INPUT-1:DATA_W] :
	                 READ_ZERO;

	////////////////////////////////////////////////////////////////
	// enable registers, bit n steers input n
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			en_a_q <= FILT_RESET;
			en_b_q <= FILT_RESET;
		end else begin
			if (wr_a)
				en_a_q <= io_req_i.wdata;
			if (wr_b)
				en_b_q <= io_req_i.wdata;
		end
	end

	// registered read answer, one cycle after the request
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_q <= READ_ZERO;
			ack_q   <= 1'b0;
		end else begin
			ack_q <= rd_hit || wr_hit;
			if (rd_hit)
				rdata_q <= rdata_d;
		end
	end

	assign filter_enable_o = {en_b_q, en_a_q};

	////////////////////////////////////////////////////////////////
	// one low-pass path per input
	for (genvar i = 0; i < NUM_INPUT; i++) begin : g_filt
		iifc_lp_filter #(
			.CYCLES(FILTER_CYCLES)
		) u_filt (
			.clk_i      (clk_i),
			.rst_b_i    (rst_b_i),
			.enable_i   (filter_enable_o[i]),
			.raw_i      (raw_inputs_i[i]),
			.filtered_o (filt[i])
		);
	end

	assign filtered_inputs_o = filt;
	assign io_rsp_o.claim    = claim;
	assign io_rsp_o.ack      = ack_q;
	assign io_rsp_o.rdata    = rdata_q;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	a_reset_filters_off: assert property ($rose(rst_b_i) |-> en_a_q == FILT_RESET && en_b_q == FILT_RESET)
		else $error("filter enables not clear after reset");
	a_write_port_a: assert property (wr_a |=> en_a_q == $past(io_req_i.wdata))
		else $error("port A enable did not take written byte");
	a_write_port_b: assert property (wr_b |=> en_b_q == $past(io_req_i.wdata))
		else $error("port B enable did not take written byte");
	a_enable_stable: assert property (!wr_a && !wr_b |=> $stable(en_a_q) && $stable(en_b_q))
		else $error("enable changed without its write");
	a_read_filt_zero: assert property (rd_hit && (at_off(off, OFF_FILT_A) || at_off(off, OFF_FILT_B))
		|=> ack_q && rdata_q == READ_ZERO && $stable(en_a_q) && $stable(en_b_q))
		else $error("enable register read not zero or had side effect");
	a_read_status_a: assert property (rd_hit && at_off(off, OFF_STATUS_A) |=> rdata_q == $past(filt[DATA_W-1:0]))
		else $error("port A status read wrong");
	a_read_status_b: assert property (rd_hit && at_off(off, OFF_STATUS_B)
		|=> rdata_q == $past(filt[NUM_INPUT-1:DATA_W]))
		else $error("port B status read wrong");
	a_outside_ignored: assert property (io_req_i.rd && !claim && !io_req_i.wr
		|=> !ack_q && $stable(en_a_q) && $stable(en_b_q))
		else $error("access outside window answered");
	a_window_claim: assert property (claim
		|-> (io_req_i.addr - {assigned_io_base_i[ADDR_W-1:WIN_BITS], WIN_BITS'(0)}) < 32'h0000_0008)
		else $error("claim outside assigned window");

	c_write_a: cover property (wr_a && io_req_i.wdata != FILT_RESET);
	c_read_status: cover property (rd_hit && at_off(off, OFF_STATUS_B) ##1 ack_q);
	c_write_then_read: cover property (wr_b ##1 rd_hit && at_off(off, OFF_FILT_B));

endmodule

// *** dv/iifc_host.sv ***
/*
 * host model: issues single-byte i/o reads and writes to the filter control block.
 * assumes the device raises its ack on the same edge that takes a request, so it is seen half a cycle later.
 */
`timescale 1ns/1ps
module iifc_host (
	input  wire logic                   clk_i,
	input  wire iifc_pkg::iifc_io_rsp_s rsp_i,
	output iifc_pkg::iifc_io_req_s      req_o
);
	import iifc_pkg::*;

	// idle bus from time zero
	initial begin
		req_o = '0;
	end

	// one access: request stands one cycle, answer sampled a cycle later
	task automatic acc(input logic rd, input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic clm, output logic ak);
		@(negedge clk_i);
		req_o = '{rd: rd, wr: wr, addr: a, wdata: d};
		#1 clm = rsp_i.claim;
		@(negedge clk_i);
		ak = rsp_i.ack;
		q  = rsp_i.rdata;
		// released bus carries the inverted address and data
		req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask
endmodule

// *** dv/isolated_input_filter_control_tb.sv ***
/*
 * self-checking bench for the filter control block, short filter count.
 * assumes the host model in iifc_host and a 125 MHz clock.
 */
`timescale 1ns/1ps
module isolated_input_filter_control_tb;
	import iifc_pkg::*;
	localparam int unsigned FC = 8;
	logic clk_i, rst_b_i, c, k;
	logic [31:0] base;
	logic [15:0] raw, fen, filt, en_m;
	logic [7:0]  q, d, o;
	iifc_io_req_s req;
	iifc_io_rsp_s rsp;
	int miscompares, num_checks, seed;

	iifc_filter_ctrl #(.FILTER_CYCLES(FC)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .assigned_io_base_i(base),
		.io_req_i(req), .io_rsp_o(rsp), .raw_inputs_i(raw), .filter_enable_o(fen), .filtered_inputs_o(filt));
	iifc_host host (.clk_i(clk_i), .rsp_i(rsp), .req_o(req));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		if (miscompares == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// weight of one input bit
	function automatic logic [7:0] bitw(input int n);
		return 8'h01 << n;
	endfunction

	// watchdog
	initial begin
		#200000;
		miscompares++;
		test_done();
	end

	initial begin
		seed = 32'h21eb;
		rst_b_i = 1'b0;
		raw = '0;
		en_m = '0;
		base = $random(seed) & 32'hffff_fff8;
		repeat (16) @(negedge clk_i);
		rst_b_i = 1'b1;
		chk(fen, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			host.acc(1'b1, 1'b0, base + i, 8'h00, q, c, k);
			chk({c, k, q}, 16'h0300);
		end
		host.acc(1'b1, 1'b0, base + 8, 8'h00, q, c, k);
		chk({c, k}, 16'h0000);
		host.acc(1'b0, 1'b1, base - 5, 8'hff, q, c, k);
		chk({c, k, fen}, 32'h0000_0000);
		for (int n = 0; n < 8; n++) begin
			host.acc(1'b0, 1'b1, base + 3, bitw(n), q, c, k);
			chk(fen, {8'h00, bitw(n)});
		end
		en_m[7:0] = 8'h80;
		repeat (40) begin
			d = $random(seed);
			o = $random(seed) & 7;
			host.acc(1'b0, 1'b1, base + o, d, q, c, k);
			if (o == 3) en_m[7:0] = d;
			if (o == 6) en_m[15:8] = d;
			chk(fen, en_m);
		end
		host.acc(1'b1, 1'b0, base + 6, 8'h00, q, c, k);
		chk({q, fen}, {16'h0000, en_m});
		host.acc(1'b0, 1'b1, base + 3, 8'h00, q, c, k);
		host.acc(1'b0, 1'b1, base + 6, 8'h00, q, c, k);
		raw = $random(seed);
		host.acc(1'b1, 1'b0, base + 1, 8'h00, q, c, k);
		chk(q, raw[7:0]);
		host.acc(1'b1, 1'b0, base + 5, 8'h00, q, c, k);
		chk(q, raw[15:8]);
		for (int n = 0; n < 8; n++)
			chk((q & bitw(n)) != 0, raw[8+n]);
		raw = '0;
		host.acc(1'b0, 1'b1, base + 3, 8'h01, q, c, k);
		raw[1:0] = 2'b11;
		repeat (FC / 2) @(negedge clk_i);
		chk(filt[1:0], 2'b10);
		repeat (FC) @(negedge clk_i);
		chk(filt[0], 1'b1);
		raw[0] = 1'b0;
		repeat (2) @(negedge clk_i);
		raw[0] = 1'b1;
		@(negedge clk_i);
		chk(filt[0], 1'b1);
		rst_b_i = 1'b0;
		repeat (2) @(negedge clk_i);
		chk(fen, 16'h0000);
		rst_b_i = 1'b1;
		host.acc(1'b1, 1'b0, base + 3, 8'h00, q, c, k);
		chk({c, k, q, fen}, 32'h0300_0000);
		test_done();
	end
endmodule
